// ---- scg_defs.svh ----
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// system control window and register offsets
`define SCG_SYSCTL_BASE     32'h400f_e000
`define SCG_RUN_CFG_OFS     12'h060
`define SCG_RUN_GATE_OFS    12'h104
`define SCG_SLEEP_GATE_OFS  12'h114
`define SCG_DEEP_GATE_OFS   12'h124
`define SCG_INT_STAT_OFS    12'h200
`define SCG_INT_MASK_OFS    12'h204

// run-mode clock configuration: automatic gating select
`define SCG_AUTO_GATE_BIT   27

// gate register fields
`define SCG_BIT_ASYNC0      0
`define SCG_BIT_ASYNC1      1
`define SCG_BIT_ASYNC2      2
`define SCG_BIT_SYNC0       4
`define SCG_BIT_SYNC1       5
`define SCG_BIT_QUAD        8
`define SCG_BIT_TWI         12
`define SCG_BIT_GPT0        16
`define SCG_BIT_GPT3        19
`define SCG_BIT_CMP0        24
`define SCG_BIT_CMP2        26
`define SCG_GATE_WR_MASK    32'h070f_1137
`define SCG_GATE_RESET      32'h0000_0000

// interrupt events
`define SCG_EV_FAULT        0
`define SCG_EV_MODE         1
`define SCG_EV_MASK         2'h3

// bus responses
`define SCG_RESP_OKAY       2'h0
`define SCG_RESP_SLVERR     2'h2

`endif

// ---- scg_periph_model.sv ----
module scg_periph_model (
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic [4:0] unit,
	input  wire logic       periph_bus_fault,
	output logic            periph_access_valid,
	output logic [4:0]      periph_access_unit,
	output logic            fault_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       pend_reg  = 1'b0;
	logic       valid_reg = 1'b0;
	logic [4:0] unit_reg  = 5'h0;
	logic       seen_reg  = 1'b0;
	assign periph_access_valid = valid_reg;
	assign periph_access_unit  = unit_reg;
	assign fault_seen          = seen_reg;
	// idle index lines wander so a stale index never passes for a request
	always @(posedge aclk) begin
		valid_reg <= go;
		unit_reg <= go ? unit : unit_reg + 5'h1;
		pend_reg <= valid_reg;
		if (pend_reg)
			seen_reg <= periph_bus_fault;
	end
endmodule

// ---- scg_pkg.sv ----
package scg_pkg;

	typedef enum logic [1:0] {
		SCG_MODE_RUN   = 2'b00,
		SCG_MODE_SLEEP = 2'b01,
		SCG_MODE_DEEP  = 2'b10
	} scg_mode_e;

	typedef struct packed {
		logic clk;
		logic en;
	} scg_gate_s;

	typedef struct packed {
		logic [31:0] run_gate;
		logic [31:0] sleep_gate;
		logic [31:0] deep_gate;
		logic        auto_gate;
		scg_mode_e   mode;
		logic [31:0] sel;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic        irq;
		logic        fault;
		logic        aw_got;
		logic        w_got;
		logic [31:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} scg_state_s;

endpackage

// ---- scg_sleep_gate.sv ----
// Overview of operation
// - each unit has its own enable bit
// - bit one clocks unit, zero stops it
// - access to gated unit gives bus fault
// - gate register resets to all zero
// - run, sleep, deep registers apply per mode
// - sleep register used only with auto gating
// - bits 26..24 gate comparators 2..0
// - bits 19..16 gate timers 3..0
// - bit 12 gates the two-wire unit
// - bit 8 gates the quadrature decoder
// - bits 5, 4 gate sync serial 1, 0
// - bits 2..0 gate async serial 2..0
// - reserved bits read zero; software preserves them
// - gate register decoded at base plus 0x114
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "scg_defs.svh"

module scg_sleep_gate
	import scg_pkg::*;
#(
	parameter int UNITS = 32
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              sleep_mode,
	input  wire logic              deep_sleep_mode,
	input  wire logic              periph_access_valid,
	input  wire logic [4:0]        periph_access_unit,
	output logic [UNITS-1:0]       unit_clk,
	output logic [UNITS-1:0]       unit_clk_en,
	output logic                   periph_bus_fault,
	output logic                   irq
);

	scg_state_s  s;
	scg_state_s  n;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic [32:0] rd_word;
	logic [1:0]  ev;

	function automatic logic hit(input logic [31:0] a, input logic [11:0] ofs);
		hit = (a == (`SCG_SYSCTL_BASE + {20'h0, ofs}));
	endfunction

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// writable gate bits only; reserved positions stay zero whatever is written
	function automatic logic [31:0] gate_bits(input logic [31:0] v);
		gate_bits = v & `SCG_GATE_WR_MASK;
	endfunction

	function automatic logic [31:0] select_gate(
		input scg_mode_e   m,
		input logic        auto_gate,
		input logic [31:0] run_g,
		input logic [31:0] sleep_g,
		input logic [31:0] deep_g
	);
		// without auto gating the run register governs every mode
		if (!auto_gate) begin
			select_gate = run_g;
		end else begin
			case (m)
				SCG_MODE_SLEEP: select_gate = sleep_g;
				SCG_MODE_DEEP:  select_gate = deep_g;
				default:        select_gate = run_g;
			endcase
		end
	endfunction

	assign aw_hs = s_axi_awvalid && s.awready;
	assign w_hs  = s_axi_wvalid && s.wready;
	assign ar_hs = s_axi_arvalid && s.arready;

	always_comb begin
		rd_word = {1'b1, 32'h0000_0000};
		if (hit(s_axi_araddr, `SCG_RUN_CFG_OFS)) begin
			rd_word[`SCG_AUTO_GATE_BIT] = s.auto_gate;
		end else if (hit(s_axi_araddr, `SCG_RUN_GATE_OFS)) begin
			rd_word[31:0] = s.run_gate;
		end else if (hit(s_axi_araddr, `SCG_SLEEP_GATE_OFS)) begin
			rd_word[31:0] = s.sleep_gate;
		end else if (hit(s_axi_araddr, `SCG_DEEP_GATE_OFS)) begin
			rd_word[31:0] = s.deep_gate;
		end else if (hit(s_axi_araddr, `SCG_INT_STAT_OFS)) begin
			rd_word[1:0] = s.irq_stat;
		end else if (hit(s_axi_araddr, `SCG_INT_MASK_OFS)) begin
			rd_word[1:0] = s.irq_mask;
		end else begin
			rd_word[32] = 1'b0;
		end
	end

	always_comb begin
		n = s;
		ev = 2'h0;

		// write channel: address and data may arrive in either order
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (aw_hs) begin
			n.aw_got  = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			n.w_got  = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		if (n.aw_got && n.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = `SCG_RESP_OKAY;
			if (hit(n.aw_addr, `SCG_RUN_CFG_OFS)) begin
				if (n.w_strb[`SCG_AUTO_GATE_BIT / 8]) begin
					n.auto_gate = n.w_data[`SCG_AUTO_GATE_BIT];
				end
			end else if (hit(n.aw_addr, `SCG_RUN_GATE_OFS)) begin
				n.run_gate = gate_bits(merge(s.run_gate, n.w_data, n.w_strb));
			end else if (hit(n.aw_addr, `SCG_SLEEP_GATE_OFS)) begin
				// stored only; takes effect through select_gate when in sleep with auto gating
				n.sleep_gate = gate_bits(merge(s.sleep_gate, n.w_data, n.w_strb));
			end else if (hit(n.aw_addr, `SCG_DEEP_GATE_OFS)) begin
				n.deep_gate = gate_bits(merge(s.deep_gate, n.w_data, n.w_strb));
			end else if (hit(n.aw_addr, `SCG_INT_STAT_OFS)) begin
				if (n.w_strb[0]) begin
					n.irq_stat = s.irq_stat & ~n.w_data[1:0];
				end
			end else if (hit(n.aw_addr, `SCG_INT_MASK_OFS)) begin
				if (n.w_strb[0]) begin
					n.irq_mask = n.w_data[1:0] & `SCG_EV_MASK;
				end
			end else begin
				n.bresp = `SCG_RESP_SLVERR;
			end
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready  = !n.w_got && !n.bvalid;

		// read channel: one outstanding read, answered on the next edge
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (ar_hs) begin
			n.rvalid = 1'b1;
			n.rdata  = rd_word[31:0];
			n.rresp  = rd_word[32] ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
		end
		n.arready = !n.rvalid;

		// deep sleep outranks sleep when both are requested
		if (deep_sleep_mode) begin
			n.mode = SCG_MODE_DEEP;
		end else if (sleep_mode) begin
			n.mode = SCG_MODE_SLEEP;
		end else begin
			n.mode = SCG_MODE_RUN;
		end
		n.sel = select_gate(s.mode, s.auto_gate, s.run_gate, s.sleep_gate, s.deep_gate);

		// fault follows the enable the unit really has, not the register
		ev[`SCG_EV_FAULT] = periph_access_valid && !unit_clk_en[periph_access_unit];
		ev[`SCG_EV_MODE]  = (n.mode != s.mode);
		n.fault = ev[`SCG_EV_FAULT];

		// an event in the cycle of its clear survives the clear
		n.irq_stat = n.irq_stat | ev;
		n.irq      = |(n.irq_stat & n.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	for (genvar k = 0; k < UNITS; k++) begin : g_unit
		scg_unit_gate u_gate (
			.aclk        (aclk),
			.aresetn     (aresetn),
			.en_req      (s.sel[k]),
			.unit_clk    (unit_clk[k]),
			.unit_clk_en (unit_clk_en[k])
		);
	end

	assign s_axi_awready    = s.awready;
	assign s_axi_wready     = s.wready;
	assign s_axi_bvalid     = s.bvalid;
	assign s_axi_bresp      = s.bresp;
	assign s_axi_arready    = s.arready;
	assign s_axi_rvalid     = s.rvalid;
	assign s_axi_rdata      = s.rdata;
	assign s_axi_rresp      = s.rresp;
	assign periph_bus_fault = s.fault;
	assign irq              = s.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_reset_zero;
		!$past(aresetn) |-> (s.sleep_gate == `SCG_GATE_RESET) && (unit_clk_en == '0);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("gate not zero after reset");

	property p_reserved_zero;
		((s.sleep_gate | s.run_gate | s.deep_gate) & ~`SCG_GATE_WR_MASK) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_sleep_select;
		(s.mode == SCG_MODE_SLEEP) && s.auto_gate |=> s.sel == $past(s.sleep_gate);
	endproperty
	a_sleep_select: assert property (p_sleep_select) else $error("sleep gate not applied");

	property p_no_auto_gate;
		!s.auto_gate |=> s.sel == $past(s.run_gate);
	endproperty
	a_no_auto_gate: assert property (p_no_auto_gate) else $error("per-mode gate used without auto gating");

	property p_run_keeps;
		(s.mode == SCG_MODE_RUN) |=> s.sel == $past(s.run_gate);
	endproperty
	a_run_keeps: assert property (p_run_keeps) else $error("sleep write changed run enables");

	property p_fault;
		periph_access_valid && !unit_clk_en[periph_access_unit] |=> periph_bus_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("no bus fault for gated unit");

	property p_no_fault;
		!periph_access_valid |=> !periph_bus_fault;
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("spurious bus fault");

	sequence s_sleep_write;
		aw_hs && w_hs && !s.bvalid && !s.aw_got && !s.w_got
			&& hit(s_axi_awaddr, `SCG_SLEEP_GATE_OFS) && (s_axi_wstrb == 4'hf);
	endsequence

	property p_sleep_write;
		s_sleep_write |=> (s.sleep_gate == ($past(s_axi_wdata) & `SCG_GATE_WR_MASK))
			&& s_axi_bvalid && (s_axi_bresp == `SCG_RESP_OKAY);
	endproperty
	a_sleep_write: assert property (p_sleep_write) else $error("sleep gate write lost");

	sequence s_sel_steady;
		$stable(s.sel) [*3];
	endsequence

	property p_enable_follows;
		s_sel_steady |-> unit_clk_en == s.sel;
	endproperty
	a_enable_follows: assert property (p_enable_follows) else $error("enable not following");

	property p_irq;
		##1 irq == |($past(n.irq_stat) & $past(n.irq_mask));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	property p_unmapped_read;
		ar_hs && !rd_word[32] |=> s_axi_rvalid && (s_axi_rresp == `SCG_RESP_SLVERR);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

	property p_deep_select;
		(s.mode == SCG_MODE_DEEP) && s.auto_gate |=> s.sel == $past(s.deep_gate);
	endproperty
	a_deep_select: assert property (p_deep_select) else $error("deep gate not applied");

	// a sleep write while running must leave the applied enables alone
	property p_run_steady;
		(s.mode == SCG_MODE_RUN) && $stable(s.mode) && $stable(s.run_gate) |=> $stable(s.sel);
	endproperty
	a_run_steady: assert property (p_run_steady) else $error("enables moved in run mode");

	property p_gated_clock_low;
		(unit_clk & ~unit_clk_en) == '0;
	endproperty
	a_gated_clock_low: assert property (p_gated_clock_low) else $error("gated unit clock high");

	property p_clocked_no_fault;
		periph_access_valid && unit_clk_en[periph_access_unit] |=> !periph_bus_fault;
	endproperty
	a_clocked_no_fault: assert property (p_clocked_no_fault) else $error("fault on clocked unit");

	property p_bvalid_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bvalid_once: assert property (p_bvalid_once) else $error("write answered twice");

	property p_rvalid_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rvalid_once: assert property (p_rvalid_once) else $error("read answered twice");

	sequence s_sleep_read;
		ar_hs && hit(s_axi_araddr, `SCG_SLEEP_GATE_OFS);
	endsequence

	property p_sleep_read;
		s_sleep_read |=> s_axi_rvalid && (s_axi_rdata == $past(s.sleep_gate))
			&& (s_axi_rresp == `SCG_RESP_OKAY);
	endproperty
	a_sleep_read: assert property (p_sleep_read) else $error("sleep gate read wrong");

endmodule

// ---- scg_unit_gate.sv ----
module scg_unit_gate
	import scg_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic en_req,
	output logic      unit_clk,
	output logic      unit_clk_en
);

	scg_gate_s s;
	scg_gate_s n;

	// the unit clock is aclk/2 from a flop; the enable moves only in its low phase
	always_comb begin
		n = s;
		if (!s.clk) begin
			n.en = en_req;
		end
		n.clk = s.clk ? 1'b0 : n.en;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign unit_clk    = s.clk;
	assign unit_clk_en = s.en;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_en_low;
		$changed(unit_clk_en) |-> !$past(unit_clk);
	endproperty
	a_en_low: assert property (p_en_low) else $error("enable changed in high phase");

	property p_no_clk_off;
		!unit_clk_en |-> !unit_clk;
	endproperty
	a_no_clk_off: assert property (p_no_clk_off) else $error("clock ran while gated");

endmodule

// ---- sleep_mode_clock_gating_one_tb.sv ----
`include "scg_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module sleep_mode_clock_gating_one_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] B = `SCG_SYSCTL_BASE;
	localparam logic [31:0] SG = B + {20'h0, `SCG_SLEEP_GATE_OFS};
	localparam logic [31:0] RG = B + {20'h0, `SCG_RUN_GATE_OFS};
	localparam logic [31:0] DG = B + {20'h0, `SCG_DEEP_GATE_OFS};
	localparam logic [31:0] CFG = B + {20'h0, `SCG_RUN_CFG_OFS};
	localparam logic [31:0] IST = B + {20'h0, `SCG_INT_STAT_OFS};
	localparam logic [31:0] IMK = B + {20'h0, `SCG_INT_MASK_OFS};
	logic        aclk = 1'b0, aresetn = 1'b0, sleep_mode = 1'b0, deep_sleep_mode = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
	logic [4:0]  unit = 5'h0, periph_access_unit;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        periph_access_valid, periph_bus_fault, irq, fault_seen;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, unit_clk, unit_clk_en, r, m, t;
	logic [33:0] q[$], e;
	int          fail_count = 0, tests_run = 0, cyc = 0;

	scg_sleep_gate dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sleep_mode, .deep_sleep_mode, .periph_access_valid,
		.periph_access_unit, .unit_clk, .unit_clk_en, .periph_bus_fault, .irq);
	scg_periph_model peer (.aclk, .go, .unit, .periph_bus_fault, .periph_access_valid,
		.periph_access_unit, .fault_seen);

	always #10 aclk = ~aclk;

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rs);
		logic ga, gw;
		@(posedge aclk);
		q.push_back({rs, 32'h0});
		ga = 1'b0;
		gw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (!ga && s_axi_awready) begin
				ga = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!gw && s_axi_wready) begin
				gw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [33:0] x);
		@(posedge aclk);
		q.push_back(x);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	task automatic acc(input logic [4:0] u, input logic f);
		@(posedge aclk);
		go <= 1'b1;
		unit <= u;
		@(posedge aclk);
		go <= 1'b0;
		repeat (4) @(posedge aclk);
		`CHK(fault_seen, f)
	endtask

	// covers mode register, select stage and the low-phase enable handover
	task automatic w6;
		repeat (6) @(posedge aclk);
	endtask

	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = q.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, e)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			e = q.pop_front();
			`CHK({s_axi_bresp, 32'h0}, e)
		end
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			end_of_test;
		end
	end

	initial begin
		r = $urandom(32'he51de805);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SG, {2'h0, `SCG_GATE_RESET});
		rd(B + 32'h118, {`SCG_RESP_SLVERR, 32'h0});
		wr(B + 32'h118, 32'hffff_ffff, `SCG_RESP_SLVERR);
		wr(SG, 32'hffff_ffff, `SCG_RESP_OKAY);
		rd(SG, {2'h0, `SCG_GATE_WR_MASK});
		r = $urandom;
		m = r & `SCG_GATE_WR_MASK;
		wr(SG, r, `SCG_RESP_OKAY);
		rd(SG, {2'h0, m});
		wr(RG, 32'h11, `SCG_RESP_OKAY);
		w6;
		`CHK(unit_clk_en, 32'h11)
		sleep_mode <= 1'b1;
		w6;
		`CHK(unit_clk_en, 32'h11)
		wr(CFG, 32'h1 << `SCG_AUTO_GATE_BIT, `SCG_RESP_OKAY);
		rd(CFG, {2'h0, 32'h1 << `SCG_AUTO_GATE_BIT});
		w6;
		`CHK(unit_clk_en, m)
		`CHK(unit_clk & ~m, 32'h0)
		t = unit_clk;
		@(posedge aclk);
		`CHK(unit_clk ^ t, m)
		wr(IST, 32'h3, `SCG_RESP_OKAY);
		wr(IMK, 32'h1, `SCG_RESP_OKAY);
		wr(SG, 32'h1, `SCG_RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		wr(SG, 32'hffff_ffff, `SCG_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(SG, {2'h0, 32'h0000_1101});
		w6;
		acc(5'h0, 1'b0);
		acc(5'h10, 1'b1);
		`CHK(irq, 1'b1)
		rd(IST, {2'h0, 32'h1});
		wr(IMK, 32'h0, `SCG_RESP_OKAY);
		w6;
		`CHK(irq, 1'b0)
		wr(IMK, 32'h1, `SCG_RESP_OKAY);
		w6;
		`CHK(irq, 1'b1)
		wr(IST, 32'h1, `SCG_RESP_OKAY);
		w6;
		`CHK(irq, 1'b0)
		wr(DG, 32'h0800_0000 | (32'h1 << `SCG_BIT_QUAD), `SCG_RESP_OKAY);
		rd(DG, {2'h0, 32'h1 << `SCG_BIT_QUAD});
		deep_sleep_mode <= 1'b1;
		w6;
		`CHK(unit_clk_en, 32'h1 << `SCG_BIT_QUAD)
		acc(5'h0, 1'b1);
		acc(5'h8, 1'b0);
		sleep_mode <= 1'b0;
		deep_sleep_mode <= 1'b0;
		w6;
		`CHK(unit_clk_en, 32'h11)
		end_of_test;
	end
endmodule
